// File: core/ecb_pkg.sv
package ecb_pkg;
	// machine clock is the input clock halved
	localparam int          CLK_HZ        = 10_000_000;
	localparam int          MCYC_DIV      = 2;
	// lcd divider half period, in input clocks
	localparam logic [7:0]  LCD_HALF_CNT  = 8'h20;

	// vector table
	localparam logic [15:0] VEC_MI_HI     = 16'hFFF8;
	localparam logic [15:0] VEC_MI_LO     = 16'hFFF9;
	localparam logic [15:0] VEC_NMI_HI    = 16'hFFFC;
	localparam logic [15:0] VEC_NMI_LO    = 16'hFFFD;
	localparam logic [15:0] VEC_RST_HI    = 16'hFFFE;
	localparam logic [15:0] VEC_RST_LO    = 16'hFFFF;

	// register byte offsets
	localparam logic [7:0]  REG_CMD       = 8'h00;
	localparam logic [7:0]  REG_ADDR      = 8'h04;
	localparam logic [7:0]  REG_WDATA     = 8'h08;
	localparam logic [7:0]  REG_ACCUM     = 8'h0C;
	localparam logic [7:0]  REG_RDATA     = 8'h10;
	localparam logic [7:0]  REG_PC        = 8'h14;
	localparam logic [7:0]  REG_FLAGS     = 8'h18;
	localparam logic [7:0]  REG_IRQ_STAT  = 8'h1C;
	localparam logic [7:0]  REG_IRQ_MASK  = 8'h20;

	// field positions
	localparam int          CMD_SEL_BIT   = 8;
	localparam int          FLAG_IE       = 0;
	localparam int          FLAG_SPARE1   = 1;
	localparam int          FLAG_SPARE2   = 2;
	localparam int          FLAG_SHOW     = 3;
	localparam int          FLAG_BUSY     = 4;
	localparam int          FLAG_STALL    = 5;
	localparam int          FLAG_GRANT    = 6;
	localparam int          NUM_EV        = 4;
	localparam int          EV_DONE       = 0;
	localparam int          EV_NMI        = 1;
	localparam int          EV_MI         = 2;
	localparam int          EV_HOLD       = 3;
	localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_MEM_RD, CMD_MEM_WR, CMD_PORT_IN, CMD_ACC_OUT,
		CMD_F1_SET, CMD_F1_CLR, CMD_F2_SET, CMD_F2_CLR, CMD_SHOW_ON, CMD_SHOW_OFF
	} ecb_cmd_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        sel_a;
		logic        sel_b;
		logic        write_n;
		logic        drive_n;
		logic        latch;
		logic [7:0]  dout;
	} ecb_bus_t;

	localparam ecb_bus_t BUS_IDLE = '{addr: 16'h0000, sel_a: 1'b0, sel_b: 1'b0,
		write_n: 1'b1, drive_n: 1'b1, latch: 1'b0, dout: 8'h00};

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ecb_ahb_ap_t;
endpackage : ecb_pkg

// File: core/ecb_clkgen.sv
`timescale 1ns/10ps
module ecb_clkgen (
	input  wire logic mclk,             // crystal-rate clock
	input  wire logic srst,             // sync reset
	input  wire logic wait_pin,         // wait request
	output logic      system_clock_out, // halved clock
	output logic      stall_latch,      // wait sampled
	output wire logic op_en             // operating clock enable
);
	import ecb_pkg::*;

	always_ff @(posedge mclk) begin
		if (srst) begin
			system_clock_out <= 1'b0;
		end else begin
			system_clock_out <= ~system_clock_out;
		end
	end

	// sample wait at the falling edge of the clock out
	always_ff @(posedge mclk) begin
		if (srst) begin
			stall_latch <= 1'b0;
		end else if (system_clock_out) begin
			stall_latch <= wait_pin;
		end
	end

	assign op_en = system_clock_out & ~stall_latch;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	chk_clock_halves: assert property ($past(srst) || system_clock_out != $past(system_clock_out))
		else $error("clock out did not toggle");
	chk_stall_sample: assert property (system_clock_out |=> stall_latch == $past(wait_pin))
		else $error("stall latch missed wait level");
	chk_stall_freeze: assert property (system_clock_out && wait_pin |-> ##2 !op_en)
		else $error("operating clock ran while stalled");
endmodule : ecb_clkgen

// File: core/ecb_lcd.sv
`timescale 1ns/10ps
module ecb_lcd (
	input  wire logic       mclk,              // clock
	input  wire logic       srst,              // sync reset
	input  wire logic       lcd_counter_clock, // backplate counter input
	output logic            lcd_divider_out,   // divided lcd clock
	output logic [7:0]      lcd_backplate_out  // backplate phases
);
	import ecb_pkg::*;

	logic [7:0] div_cnt;
	logic       cc_prev;
	logic [2:0] bp_cnt;
	logic [2:0] next_bp_cnt;

	always_ff @(posedge mclk) begin
		if (srst) begin
			div_cnt         <= 8'h00;
			lcd_divider_out <= 1'b0;
		end else if (div_cnt == LCD_HALF_CNT - 8'h01) begin
			div_cnt         <= 8'h00;
			lcd_divider_out <= ~lcd_divider_out;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	assign next_bp_cnt = (lcd_counter_clock && !cc_prev) ? bp_cnt + 3'h1 : bp_cnt;

	always_ff @(posedge mclk) begin
		if (srst) begin
			cc_prev <= 1'b0;
			bp_cnt  <= 3'h0;
		end else begin
			cc_prev <= lcd_counter_clock;
			bp_cnt  <= next_bp_cnt;
		end
	end

	for (genvar i = 0; i < 8; i++) begin : g_bp
		always_ff @(posedge mclk) begin
			if (srst) begin
				lcd_backplate_out[i] <= (i == 0);
			end else begin
				lcd_backplate_out[i] <= (next_bp_cnt == 3'(i));
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	chk_backplate_onehot: assert property ($onehot(lcd_backplate_out))
		else $error("backplate outputs not one-hot");
	chk_backplate_step: assert property (lcd_counter_clock && !cc_prev |=> bp_cnt == $past(bp_cnt) + 3'h1)
		else $error("backplate counter missed an edge");
endmodule : ecb_lcd

// File: core/ecb_top.sv
`timescale 1ns/10ps
module ecb_top (
	input  wire logic        mclk,              // 10 MHz clock
	input  wire logic        srst,              // sync reset, high
	input  wire logic        hsel,              // ahb select
	input  wire logic [31:0] haddr,             // ahb address
	input  wire logic [1:0]  htrans,            // ahb transfer type
	input  wire logic        hwrite,            // ahb write
	input  wire logic [2:0]  hsize,             // ahb size
	input  wire logic [31:0] hwdata,            // ahb write data
	input  wire logic        hready,            // ahb ready in
	output logic             hreadyout,         // ahb ready out
	output logic             hresp,             // ahb response
	output logic [31:0]      hrdata,            // ahb read data
	output logic             irq,               // interrupt, high
	output logic [15:0]      addr_out,          // address pins
	output logic             addr_oe_n,         // address enable, low
	output logic [7:0]       data_out,          // data pins out
	input  wire logic [7:0]  data_in,           // data pins in
	output logic             data_oe_n,         // data enable, low
	output logic             space_select_a,    // space a select
	output logic             space_select_b,    // space b select
	output logic             write_n,           // write strobe, low
	output logic             bus_drive_strobe,  // drive strobe, low
	output logic             ctrl_oe_n,         // control pins enable, low
	output logic             port_latch_clk,    // external latch clock
	input  wire logic        bus_hold_request,  // bus request
	output logic             bus_hold_grant,    // bus grant
	input  wire logic        maskable_irq_pin,  // maskable request
	input  wire logic        nmi_pin,           // non-maskable request
	input  wire logic        wait_pin,          // wait request
	input  wire logic [7:0]  eight_bit_sense_port, // input port
	output logic             spare_flag_one,    // flag one
	output logic             spare_flag_two,    // flag two
	output logic             lcd_show_ctrl,     // display on
	output logic             system_clock_out,  // halved clock
	output logic             lcd_divider_out,   // lcd clock
	input  wire logic        lcd_counter_clock, // backplate counter in
	output logic [7:0]       lcd_backplate_out  // backplates
);
	import ecb_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RD, ST_WR, ST_PORT, ST_LATCH, ST_VEC_HI, ST_VEC_LO, ST_HOLD
	} ecb_state_t;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction : hit

	ecb_state_t        state;
	ecb_bus_t          bus_q;
	ecb_ahb_ap_t       ap_q;
	logic              op_en;
	logic              stall_latch;
	logic              wr_en;
	logic              interrupt_enable_flag;
	logic [7:0]        accum;
	logic [7:0]        rd_byte;
	logic [15:0]       pc;
	logic [15:0]       vec_lo;
	logic              cmd_pending;
	ecb_cmd_t          cmd_code;
	logic              cmd_sel;
	logic [15:0]       addr_reg;
	logic [7:0]        wdata_reg;
	logic [NUM_EV-1:0] ev_q;
	logic [NUM_EV-1:0] irq_stat;
	logic [NUM_EV-1:0] irq_mask;
	logic [NUM_EV-1:0] next_irq_stat;
	logic              busy;
	logic              boundary;
	logic              take_nmi;
	logic              take_mi;
	logic              take_hold;
	logic              take_cmd;
	logic [31:0]       rd_mux;

	ecb_clkgen u_clkgen (
		.mclk             (mclk),
		.srst             (srst),
		.wait_pin         (wait_pin),
		.system_clock_out (system_clock_out),
		.stall_latch      (stall_latch),
		.op_en            (op_en)
	);

	ecb_lcd u_lcd (
		.mclk              (mclk),
		.srst              (srst),
		.lcd_counter_clock (lcd_counter_clock),
		.lcd_divider_out   (lcd_divider_out),
		.lcd_backplate_out (lcd_backplate_out)
	);

	// ahb slave: one wait state per transfer
	always_ff @(posedge mclk) begin
		if (srst) begin
			ap_q      <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else if (ap_q.valid) begin
			ap_q.valid <= 1'b0;
			hreadyout  <= 1'b1;
			if (!ap_q.write) begin
				hrdata <= rd_mux;
			end
		end else if (hsel && htrans[1] && hready) begin
			ap_q      <= '{valid: 1'b1, write: hwrite, addr: haddr[7:0]};
			hreadyout <= 1'b0;
		end
	end

	assign wr_en = ap_q.valid && ap_q.write;
	assign busy  = cmd_pending || (state != ST_IDLE);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(ap_q.addr, REG_CMD)) begin
			rd_mux[FLAG_BUSY] = busy;
		end else if (hit(ap_q.addr, REG_ADDR)) begin
			rd_mux[15:0] = addr_reg;
		end else if (hit(ap_q.addr, REG_WDATA)) begin
			rd_mux[7:0] = wdata_reg;
		end else if (hit(ap_q.addr, REG_ACCUM)) begin
			rd_mux[7:0] = accum;
		end else if (hit(ap_q.addr, REG_RDATA)) begin
			rd_mux[7:0] = rd_byte;
		end else if (hit(ap_q.addr, REG_PC)) begin
			rd_mux[15:0] = pc;
		end else if (hit(ap_q.addr, REG_FLAGS)) begin
			rd_mux[FLAG_IE]     = interrupt_enable_flag;
			rd_mux[FLAG_SPARE1] = spare_flag_one;
			rd_mux[FLAG_SPARE2] = spare_flag_two;
			rd_mux[FLAG_SHOW]   = lcd_show_ctrl;
			rd_mux[FLAG_BUSY]   = busy;
			rd_mux[FLAG_STALL]  = stall_latch;
			rd_mux[FLAG_GRANT]  = bus_hold_grant;
		end else if (hit(ap_q.addr, REG_IRQ_STAT)) begin
			rd_mux[NUM_EV-1:0] = irq_stat;
		end else if (hit(ap_q.addr, REG_IRQ_MASK)) begin
			rd_mux[NUM_EV-1:0] = irq_mask;
		end
	end

	// boundary decisions: hold, then nmi, then maskable, then command
	assign boundary  = op_en && (state == ST_IDLE);
	assign take_hold = boundary && bus_hold_request;
	assign take_nmi  = boundary && !bus_hold_request && nmi_pin;
	assign take_mi   = boundary && !bus_hold_request && !nmi_pin
		&& interrupt_enable_flag && maskable_irq_pin;
	assign take_cmd  = boundary && !bus_hold_request && !nmi_pin
		&& !(interrupt_enable_flag && maskable_irq_pin) && cmd_pending;

	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_pending <= 1'b0;
			cmd_code    <= CMD_NOP;
			cmd_sel     <= 1'b0;
			addr_reg    <= 16'h0000;
			wdata_reg   <= 8'h00;
		end else begin
			if (take_cmd) begin
				cmd_pending <= 1'b0;
			end
			if (wr_en && hit(ap_q.addr, REG_CMD) && !busy) begin
				cmd_pending <= 1'b1;
				cmd_code    <= ecb_cmd_t'(hwdata[3:0]);
				cmd_sel     <= hwdata[CMD_SEL_BIT];
			end
			if (wr_en && hit(ap_q.addr, REG_ADDR)) begin
				addr_reg <= hwdata[15:0];
			end
			if (wr_en && hit(ap_q.addr, REG_WDATA)) begin
				wdata_reg <= hwdata[7:0];
			end
		end
	end

	// flag flip-flops: spare and show flags changed only by commands; ie by a flags register write, cleared when a maskable interrupt is taken
	always_ff @(posedge mclk) begin
		if (srst) begin
			interrupt_enable_flag <= 1'b0;
			spare_flag_one        <= 1'b0;
			spare_flag_two        <= 1'b0;
			lcd_show_ctrl         <= 1'b0;
		end else begin
			if (wr_en && hit(ap_q.addr, REG_FLAGS)) begin
				interrupt_enable_flag <= hwdata[FLAG_IE];
			end
			if (take_mi) begin
				interrupt_enable_flag <= 1'b0;
			end
			if (take_cmd) begin
				unique case (cmd_code)
					CMD_F1_SET:   spare_flag_one <= 1'b1;
					CMD_F1_CLR:   spare_flag_one <= 1'b0;
					CMD_F2_SET:   spare_flag_two <= 1'b1;
					CMD_F2_CLR:   spare_flag_two <= 1'b0;
					CMD_SHOW_ON:  lcd_show_ctrl  <= 1'b1;
					CMD_SHOW_OFF: lcd_show_ctrl  <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			accum   <= 8'h00;
			rd_byte <= 8'h00;
		end else if (op_en && state == ST_RD) begin
			accum   <= data_in;
			rd_byte <= data_in;
		end else if (op_en && state == ST_PORT) begin
			accum <= eight_bit_sense_port;
		end else if (wr_en && hit(ap_q.addr, REG_ACCUM)) begin
			accum <= hwdata[7:0];
		end
	end

	// bus sequencer; reset starts with the reset vector fetch
	always_ff @(posedge mclk) begin
		if (srst) begin
			state          <= ST_VEC_HI;
			bus_q          <= BUS_IDLE;
			bus_q.addr     <= VEC_RST_HI;
			bus_q.sel_a    <= 1'b1;
			vec_lo         <= VEC_RST_LO;
			pc             <= 16'h0000;
			addr_oe_n      <= 1'b0;
			ctrl_oe_n      <= 1'b0;
			data_oe_n      <= 1'b1;
			bus_hold_grant <= 1'b0;
			ev_q           <= '0;
		end else begin
			ev_q <= '0;
			if (op_en) begin
				unique case (state)
					ST_IDLE: begin
						if (take_hold) begin
							state          <= ST_HOLD;
							bus_hold_grant <= 1'b1;
							addr_oe_n      <= 1'b1;
							ctrl_oe_n      <= 1'b1;
							data_oe_n      <= 1'b1;
							ev_q[EV_HOLD]  <= 1'b1;
						end else if (take_nmi || take_mi) begin
							state       <= ST_VEC_HI;
							bus_q.addr  <= take_nmi ? VEC_NMI_HI : VEC_MI_HI;
							bus_q.sel_a <= 1'b1;
							vec_lo      <= take_nmi ? VEC_NMI_LO : VEC_MI_LO;
							ev_q[EV_NMI] <= take_nmi;
							ev_q[EV_MI]  <= take_mi;
						end else if (take_cmd) begin
							bus_q.addr  <= addr_reg;
							bus_q.sel_a <= (cmd_code inside {CMD_MEM_RD, CMD_MEM_WR}) && !cmd_sel;
							bus_q.sel_b <= (cmd_code inside {CMD_MEM_RD, CMD_MEM_WR}) && cmd_sel;
							unique case (cmd_code)
								CMD_MEM_RD: state <= ST_RD;
								CMD_MEM_WR: begin
									state         <= ST_WR;
									bus_q.write_n <= 1'b0;
									bus_q.drive_n <= 1'b0;
									bus_q.dout    <= wdata_reg;
									data_oe_n     <= 1'b0;
								end
								CMD_PORT_IN: state <= ST_PORT;
								CMD_ACC_OUT: begin
									state         <= ST_LATCH;
									bus_q.latch   <= 1'b1;
									bus_q.drive_n <= 1'b0;
									bus_q.dout    <= accum;
									data_oe_n     <= 1'b0;
								end
								default: ev_q[EV_DONE] <= 1'b1;
							endcase
						end
					end
					ST_RD, ST_WR, ST_PORT, ST_LATCH: begin
						state         <= ST_IDLE;
						bus_q         <= BUS_IDLE;
						data_oe_n     <= 1'b1;
						ev_q[EV_DONE] <= 1'b1;
					end
					ST_VEC_HI: begin
						pc[15:8]   <= data_in;
						bus_q.addr <= vec_lo;
						state      <= ST_VEC_LO;
					end
					ST_VEC_LO: begin
						pc[7:0] <= data_in;
						bus_q   <= BUS_IDLE;
						state   <= ST_IDLE;
					end
					ST_HOLD: begin
						if (!bus_hold_request) begin
							state          <= ST_IDLE;
							bus_hold_grant <= 1'b0;
							addr_oe_n      <= 1'b0;
							ctrl_oe_n      <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	assign addr_out         = bus_q.addr;
	assign space_select_a   = bus_q.sel_a;
	assign space_select_b   = bus_q.sel_b;
	assign write_n          = bus_q.write_n;
	assign bus_drive_strobe = bus_q.drive_n;
	assign port_latch_clk   = bus_q.latch;
	assign data_out         = bus_q.dout;

	// sticky events, set wins over write-one-to-clear
	always_comb begin
		next_irq_stat = irq_stat;
		if (wr_en && hit(ap_q.addr, REG_IRQ_STAT)) begin
			next_irq_stat = irq_stat & ~hwdata[NUM_EV-1:0];
		end
		next_irq_stat = next_irq_stat | ev_q;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_stat <= '0;
			irq_mask <= IRQ_MASK_RST;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
			if (wr_en && hit(ap_q.addr, REG_IRQ_MASK)) begin
				irq_mask <= hwdata[NUM_EV-1:0];
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	chk_hold_float: assert property (bus_hold_grant |-> addr_oe_n && ctrl_oe_n && data_oe_n)
		else $error("pins driven during bus hold");
	chk_hold_grant: assert property (take_hold |=> bus_hold_grant && state == ST_HOLD)
		else $error("bus request not granted");
	chk_write_drive: assert property (!write_n |-> !data_oe_n && !bus_drive_strobe)
		else $error("write without data drive");
	chk_latch_data: assert property (port_latch_clk |-> data_out == accum && !data_oe_n)
		else $error("latch clock without accumulator on bus");
	chk_select_single: assert property (!(space_select_a && space_select_b))
		else $error("both space selects active");
	chk_port_read: assert property (op_en && state == ST_PORT |=> accum == $past(eight_bit_sense_port))
		else $error("port read lost");
	// a wait sampled at the accepting edge legally delays the second fetch
	chk_nmi_first: assert property (take_nmi && !wait_pin
		|=> addr_out == VEC_NMI_HI ##2 addr_out == VEC_NMI_LO)
		else $error("nmi vector not fetched first");
	chk_mi_vector: assert property (take_mi && !wait_pin
		|=> addr_out == VEC_MI_HI ##2 addr_out == VEC_MI_LO)
		else $error("maskable vector wrong");
	chk_reset_vector: assert property ($fell(srst) |-> addr_out == VEC_RST_HI && state == ST_VEC_HI)
		else $error("reset vector fetch missing");
	chk_flag_cmd: assert property (take_cmd && cmd_code == CMD_F1_SET |=> spare_flag_one)
		else $error("flag one not set");
	chk_stall_hold: assert property (stall_latch |=> $stable(state) && $stable(pc))
		else $error("sequencer moved while stalled");
endmodule : ecb_top

// File: tb/ecb_mem_model.sv
`timescale 1ns/10ps
module ecb_mem_model (
	input  wire logic        mclk,           // clock
	input  wire logic [15:0] addr_out,       // address pins
	input  wire logic [7:0]  data_out,       // device data out
	input  wire logic        data_oe_n,      // device drives data, low
	input  wire logic        space_select_a, // space a select
	input  wire logic        space_select_b, // space b select
	input  wire logic        write_n,        // write strobe, low
	input  wire logic        ctrl_oe_n,      // control pins driven, low
	output logic [7:0]       data_in         // resolved data pin level
);
	logic [7:0]  mem [0:131071];
	logic [7:0]  last = 8'h00;
	logic [16:0] key;
	logic        sel;
	initial begin
		for (int i = 0; i < 131072; i++) begin
			mem[i] = i[7:0] ^ 8'h5A;
		end
	end
	assign key = {space_select_b, addr_out};
	assign sel = (space_select_a | space_select_b) & ~ctrl_oe_n;
	// undriven bus toggles so stale data never looks valid
	assign data_in = !data_oe_n ? data_out : (sel && write_n) ? mem[key] : ~last;
	always @(posedge mclk) begin
		last <= data_in;
		if (sel && !write_n) begin
			mem[key] <= data_out;
		end
	end
endmodule : ecb_mem_model

// File: tb/ecb_tb_top.sv
`timescale 1ns/10ps
module ecb_tb_top;
	import ecb_pkg::*;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, bus_hold_request = 1'b0, wait_pin = 1'b0;
	logic        maskable_irq_pin = 1'b0, nmi_pin = 1'b0, lcd_counter_clock = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [7:0]  eight_bit_sense_port = 8'h00;
	logic [7:0]  data_out, data_in, lcd_backplate_out, wr_data, latch_data;
	logic [15:0] addr_out, wr_addr;
	logic        hready, hreadyout, hresp, irq, addr_oe_n, data_oe_n, wr_oe, s;
	logic        space_select_a, space_select_b, write_n, bus_drive_strobe, ctrl_oe_n;
	logic        port_latch_clk, bus_hold_grant, spare_flag_one, spare_flag_two;
	logic        lcd_show_ctrl, system_clock_out, lcd_divider_out;
	int          num_errors = 0;
	int          checked = 0;
	logic [3:0]  row_cmd [6] = '{4'h5, 4'h7, 4'h9, 4'h6, 4'h8, 4'hA};
	logic [2:0]  row_exp [6] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};

	assign hready = hreadyout;
	ecb_top i_dut (.*);
	ecb_mem_model i_mem (.*);

	initial begin
		forever #50 mclk = ~mclk;
	end

	// capture what the device put on the pins
	always @(posedge mclk) begin
		if (!write_n && !ctrl_oe_n) begin
			wr_addr <= addr_out;
			wr_data <= data_out;
			wr_oe <= bus_drive_strobe | data_oe_n;
		end
		if (port_latch_clk) begin
			latch_data <= data_out;
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hwdata <= d;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		r = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb

	task automatic poll(input logic [7:0] a, input int b, input logic v);
		for (int i = 0; i < 100; i++) begin
			ahb(1'b0, a, 32'h0);
			if (r[b] === v) break;
		end
		chk("polled bit", {31'h0, v}, {31'h0, r[b]});
	endtask : poll

	task automatic cmd(input logic [8:0] c);
		ahb(1'b1, REG_CMD, {23'h0, c});
		poll(REG_FLAGS, FLAG_BUSY, 1'b0);
	endtask : cmd

	task automatic give_verdict;
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		give_verdict;
	end

	initial begin
		repeat (2) @(posedge mclk);
		chk("reset addr", 32'hFFFE, {16'h0, addr_out});
		chk("backplate", 32'h01, {24'h0, lcd_backplate_out});
		srst <= 1'b0;
		repeat (10) @(posedge mclk);
		ahb(1'b0, REG_PC, 32'h0);
		chk("reset pc", 32'hA4A5, r);
		for (int i = 0; i < 6; i++) begin
			cmd({5'h0, row_cmd[i]});
			chk("flag pins", {29'h0, row_exp[i]}, {29'h0, lcd_show_ctrl, spare_flag_two, spare_flag_one});
		end
		// memory write, then reads from both spaces
		ahb(1'b1, REG_ADDR, 32'h1234);
		ahb(1'b1, REG_WDATA, 32'h3C);
		cmd(9'h002);
		chk("write addr", 32'h1234, {16'h0, wr_addr});
		chk("write data", 32'h3C, {24'h0, wr_data});
		chk("write drive", 32'h0, {31'h0, wr_oe});
		cmd(9'h101);
		ahb(1'b0, REG_RDATA, 32'h0);
		chk("space b read", 32'h6E, r);
		cmd(9'h001);
		ahb(1'b0, REG_RDATA, 32'h0);
		chk("space a read", 32'h3C, r);
		eight_bit_sense_port <= 8'hC3;
		cmd(9'h003);
		ahb(1'b0, REG_ACCUM, 32'h0);
		chk("port read", 32'hC3, r);
		ahb(1'b1, REG_ACCUM, 32'h96);
		cmd(9'h004);
		chk("latch data", 32'h96, {24'h0, latch_data});
		// interrupt output: raise, clear, mask
		ahb(1'b1, REG_IRQ_STAT, 32'hF);
		ahb(1'b1, REG_IRQ_MASK, 32'h1);
		cmd(9'h000);
		chk("irq set", 32'h1, {31'h0, irq});
		ahb(1'b1, REG_IRQ_STAT, 32'h1);
		@(posedge mclk);
		chk("irq clear", 32'h0, {31'h0, irq});
		ahb(1'b1, REG_IRQ_MASK, 32'h0);
		cmd(9'h000);
		chk("irq masked", 32'h0, {31'h0, irq});
		nmi_pin <= 1'b1;
		poll(REG_IRQ_STAT, EV_NMI, 1'b1);
		nmi_pin <= 1'b0;
		repeat (10) @(posedge mclk);
		ahb(1'b0, REG_PC, 32'h0);
		chk("nmi pc", 32'hA6A7, r);
		maskable_irq_pin <= 1'b1;
		repeat (20) @(posedge mclk);
		ahb(1'b0, REG_IRQ_STAT, 32'h0);
		chk("mi blocked", 32'h0, {31'h0, r[EV_MI]});
		ahb(1'b1, REG_FLAGS, 32'h1);
		poll(REG_IRQ_STAT, EV_MI, 1'b1);
		maskable_irq_pin <= 1'b0;
		repeat (10) @(posedge mclk);
		ahb(1'b0, REG_PC, 32'h0);
		chk("mi pc", 32'hA2A3, r);
		ahb(1'b0, REG_FLAGS, 32'h0);
		chk("ie cleared", 32'h0, {31'h0, r[FLAG_IE]});
		bus_hold_request <= 1'b1;
		poll(REG_FLAGS, FLAG_GRANT, 1'b1);
		chk("hold float", 32'hF, {28'h0, bus_hold_grant, addr_oe_n, data_oe_n, ctrl_oe_n});
		bus_hold_request <= 1'b0;
		poll(REG_FLAGS, FLAG_GRANT, 1'b0);
		chk("hold end", 32'h0, {31'h0, addr_oe_n});
		// command held back while stalled
		wait_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		ahb(1'b1, REG_CMD, 32'h5);
		repeat (20) @(posedge mclk);
		ahb(1'b0, REG_FLAGS, 32'h0);
		chk("stalled", 32'h30, r & 32'h32);
		s = system_clock_out;
		@(posedge mclk);
		chk("clock out", {31'h0, ~s}, {31'h0, system_clock_out});
		wait_pin <= 1'b0;
		poll(REG_FLAGS, FLAG_BUSY, 1'b0);
		chk("resumed", 32'h1, {31'h0, spare_flag_one});
		// reset again mid-run, flag one set beforehand
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("rerun addr", 32'hFFFE, {16'h0, addr_out});
		chk("rerun flags", 32'h0, {29'h0, lcd_show_ctrl, spare_flag_two, spare_flag_one});
		srst <= 1'b0;
		repeat (10) @(posedge mclk);
		ahb(1'b0, REG_PC, 32'h0);
		chk("rerun pc", 32'hA4A5, r);
		lcd_counter_clock <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("backplate step", 32'h02, {24'h0, lcd_backplate_out});
		// lcd divider half period
		s = lcd_divider_out;
		while (lcd_divider_out === s) @(posedge mclk);
		repeat (LCD_HALF_CNT - 8'h01) @(posedge mclk);
		chk("lcd divider hold", {31'h0, ~s}, {31'h0, lcd_divider_out});
		@(posedge mclk);
		chk("lcd divider step", {31'h0, s}, {31'h0, lcd_divider_out});
		give_verdict;
	end
endmodule : ecb_tb_top
